// [verilog/bss_defs.svh]
// offsets, fields, reset values and decode constants for the set-point block
`ifndef BSS_DEFS_SVH
`define BSS_DEFS_SVH
`define BSS_OFF_NORMAL 8'h00
`define BSS_OFF_STANDBY 8'h04
`define BSS_OFF_SLEEP 8'h08
`define BSS_OFF_MODE 8'h0C
`define BSS_OFF_STATUS 8'h10
`define BSS_RANGE_BIT 6
`define BSS_STEP_LO_UV 25000
`define BSS_STEP_HI_UV 50000
`define BSS_BASE_LO_UV 400000
`define BSS_BASE_HI_UV 800000
`define BSS_MIN_OK_UV 600000
`define BSS_CODE_RST 6'h00
`define BSS_MAX_HI_CODE 6'h32
`endif

// [verilog/bss_pkg.sv]
// types for the set-point block
package bss_pkg;
    typedef enum logic [1:0] {BSS_NORMAL, BSS_STANDBY, BSS_SLEEP} bss_mode_e;
    typedef struct packed {
        logic [1:0] htrans;
        logic [7:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
    } bss_addr_s;
    typedef struct packed {
        logic [6:0] code;
        logic [21:0] microvolt;
        logic too_low;
        logic reserved;
    } bss_out_s;
endpackage : bss_pkg

// [verilog/bss_decode.sv]
// seven-bit code to microvolt decoder, registered output
`timescale 1ns/1ps
`include "bss_defs.svh"
module bss_decode (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [6:0] code,
    output bss_pkg::bss_out_s dec
);
    import bss_pkg::*;
    bss_out_s dec_nxt;
    logic [21:0] uv;
    always_comb begin
        if (code[`BSS_RANGE_BIT]) begin
            uv = 22'(`BSS_BASE_HI_UV) + 22'(code[5:0]) * 22'(`BSS_STEP_HI_UV);
        end else begin
            uv = 22'(`BSS_BASE_LO_UV) + 22'(code[5:0]) * 22'(`BSS_STEP_LO_UV);
        end
        dec_nxt.code = code;
        dec_nxt.microvolt = uv;
        dec_nxt.too_low = (uv <= 22'(`BSS_MIN_OK_UV));
        dec_nxt.reserved = code[6] && (code[5:0] > `BSS_MAX_HI_CODE);
    end
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dec <= '0;
        end else begin
            dec <= dec_nxt;
        end
    end
endmodule : bss_decode

// [verilog/bss_setpoint.sv]
// buck set-point register block with AHB-Lite slave
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "bss_defs.svh"
module bss_setpoint (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic range_cfg,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic [6:0] active_code,
    output logic [21:0] active_microvolt,
    output logic setpoint_too_low,
    output logic setpoint_reserved
);
    import bss_pkg::*;
    bss_addr_s aph_r, aph_nxt;
    logic wr_pend_r, wr_pend_nxt;
    logic range_r, range_nxt;
    logic range_meta_r, range_sync_r;
    logic [1:0] settle_r, settle_nxt;
    logic range_loaded_r, range_loaded_nxt;
    logic [5:0] norm_r, norm_nxt;
    logic [5:0] stby_r, stby_nxt;
    logic [5:0] slp_r, slp_nxt;
    bss_mode_e mode_r, mode_nxt;
    logic [31:0] rdata_nxt;
    logic [6:0] sel_code;
    bss_out_s dec;
    logic take;

    // two-flop synchroniser for the strap pin, free running
    always_ff @(posedge core_clk) begin
        range_meta_r <= range_cfg;
        range_sync_r <= range_meta_r;
    end

    // range strap caught once after reset release
    always_comb begin
        range_nxt = range_r;
        range_loaded_nxt = 1'b1;
        if (!range_loaded_r) begin
            range_nxt = range_sync_r;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            range_r <= 1'b0;
            range_loaded_r <= 1'b0;
        end else begin
            range_r <= range_nxt;
            range_loaded_r <= range_loaded_nxt;
        end
    end

    // outputs carry decoded values two edges after release
    always_comb begin
        settle_nxt = {settle_r[0], 1'b1};
    end
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            settle_r <= 2'h0;
        end else begin
            settle_r <= settle_nxt;
        end
    end

    // bus address phase capture
    assign take = hsel && hready && htrans[1];
    always_comb begin
        aph_nxt = aph_r;
        wr_pend_nxt = 1'b0;
        if (hready) begin
            aph_nxt = '{htrans, haddr, hwrite, hsize, hsel};
            wr_pend_nxt = take && hwrite;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            aph_r <= '0;
            wr_pend_r <= 1'b0;
        end else begin
            aph_r <= aph_nxt;
            wr_pend_r <= wr_pend_nxt;
        end
    end

    // set-point codes, written in the data phase
    always_comb begin
        norm_nxt = norm_r;
        stby_nxt = stby_r;
        slp_nxt = slp_r;
        mode_nxt = mode_r;
        if (wr_pend_r) begin
            case (aph_r.haddr)
                `BSS_OFF_NORMAL: norm_nxt = hwdata[5:0];
                `BSS_OFF_STANDBY: stby_nxt = hwdata[5:0];
                `BSS_OFF_SLEEP: slp_nxt = hwdata[5:0];
                `BSS_OFF_MODE: begin
                    case (hwdata[1:0])
                        2'h1: mode_nxt = BSS_STANDBY;
                        2'h2: mode_nxt = BSS_SLEEP;
                        default: mode_nxt = BSS_NORMAL;
                    endcase
                end
                default: ;
            endcase
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            norm_r <= `BSS_CODE_RST;
            stby_r <= `BSS_CODE_RST;
            slp_r <= `BSS_CODE_RST;
            mode_r <= BSS_NORMAL;
        end else begin
            norm_r <= norm_nxt;
            stby_r <= stby_nxt;
            slp_r <= slp_nxt;
            mode_r <= mode_nxt;
        end
    end

    // active code: one shared range bit for all modes
    always_comb begin
        case (mode_r)
            BSS_STANDBY: sel_code = {range_r, stby_r};
            BSS_SLEEP: sel_code = {range_r, slp_r};
            default: sel_code = {range_r, norm_r};
        endcase
    end

    bss_decode u_dec (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .code(sel_code),
        .dec(dec)
    );

    // read data and outputs
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (take && !hwrite) begin
            case (haddr)
                `BSS_OFF_NORMAL: rdata_nxt = {25'h0, range_r, norm_r};
                `BSS_OFF_STANDBY: rdata_nxt = {25'h0, range_r, stby_r};
                `BSS_OFF_SLEEP: rdata_nxt = {25'h0, range_r, slp_r};
                `BSS_OFF_MODE: rdata_nxt = {30'h0, mode_r};
                `BSS_OFF_STATUS: rdata_nxt = {dec.reserved, dec.too_low,
                    1'b0, dec.code, dec.microvolt};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            active_code <= 7'h00;
            active_microvolt <= 22'h000000;
            setpoint_too_low <= 1'b0;
            setpoint_reserved <= 1'b0;
        end else begin
            hrdata <= rdata_nxt;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            active_code <= dec.code;
            active_microvolt <= dec.microvolt;
            setpoint_too_low <= dec.too_low;
            setpoint_reserved <= dec.reserved;
        end
    end

    // checks
    sequence s_wr_norm;
        take && hwrite && haddr == `BSS_OFF_NORMAL;
    endsequence

    sequence s_rd_norm;
        take && !hwrite && haddr == `BSS_OFF_NORMAL;
    endsequence

    // all codes and the range bit unchanged over two edges
    sequence s_codes_steady;
        $stable(norm_r) && $stable(stby_r) && $stable(slp_r)
            && $stable(range_r)
            ##1 $stable(norm_r) && $stable(stby_r) && $stable(slp_r)
            && $stable(range_r);
    endsequence

    AST_RANGE_HOLD: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        range_loaded_r |=> $stable(range_r))
        else $error("range bit changed after load");

    AST_RANGE_LOAD: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !range_loaded_r |=> range_r == $past(range_sync_r))
        else $error("range bit not taken from strap");

    AST_RANGE_READ: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        s_rd_norm |=> hrdata[6] == $past(range_r))
        else $error("read range bit differs");

    AST_WR_IGNORE_RANGE: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        s_wr_norm ##1 1'b1 |=> norm_r == $past(hwdata[5:0])
            && range_r == $past(range_r, 2))
        else $error("normal write wrong or range touched");

    AST_LOW_RANGE: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        settle_r[1] && !active_code[6] |-> active_microvolt ==
            22'(`BSS_BASE_LO_UV)
            + 22'(active_code[5:0]) * 22'(`BSS_STEP_LO_UV))
        else $error("low range decode wrong");

    AST_HIGH_RANGE: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        settle_r[1] && active_code[6] |-> active_microvolt ==
            22'(`BSS_BASE_HI_UV)
            + 22'(active_code[5:0]) * 22'(`BSS_STEP_HI_UV))
        else $error("high range decode wrong");

    AST_NORMAL_SELECT: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        mode_r == BSS_NORMAL ##1 s_codes_steady
            |-> active_code == {range_r, norm_r})
        else $error("normal code not applied");

    AST_STANDBY_SELECT: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        mode_r == BSS_STANDBY ##1 s_codes_steady
            |-> active_code == {range_r, stby_r})
        else $error("standby code not applied");

    AST_MODE_SELECT: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        mode_r == BSS_SLEEP ##1 s_codes_steady
            |-> active_code == {range_r, slp_r})
        else $error("sleep code not applied");

    AST_SHARED_RANGE: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        range_loaded_r ##2 1'b1 |-> active_code[6] == range_r)
        else $error("mode range differs");

    AST_ZERO_CODE: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        settle_r[1] && active_code == 7'h00
            |-> active_microvolt == 22'h061A80 && setpoint_too_low)
        else $error("code zero not 0.4 V");

    AST_HIGH_BASE: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        settle_r[1] && active_code == 7'h40
            |-> active_microvolt == 22'h0C3500 && !setpoint_too_low)
        else $error("code 0x40 not 0.8 V");

    AST_TOO_LOW_FLAG: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        settle_r[1] |-> setpoint_too_low
            == (active_microvolt <= 22'(`BSS_MIN_OK_UV)))
        else $error("too-low flag wrong");

    AST_RESERVED_FLAG: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        settle_r[1] |-> setpoint_reserved
            == (active_code[6] && active_code[5:0] > 6'h32))
        else $error("reserved flag wrong");
endmodule : bss_setpoint

// [dv/test_buck_setpoint_select.sv]
// self-checking bench for the buck set-point register block
`timescale 1ns/1ps
`include "bss_defs.svh"
module test_buck_setpoint_select;
    typedef struct packed {
        logic rng;
        logic [1:0] mode;
        logic [5:0] code;
        logic [21:0] uv;
        logic low;
        logic res;
    } bss_row_s;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic range_cfg = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    wire logic hready;
    logic hreadyout;
    logic hresp;
    logic [6:0] active_code;
    logic [21:0] active_microvolt;
    logic setpoint_too_low;
    logic setpoint_reserved;
    logic [5:0] lastc [3];
    int err_total = 0;
    int checks_done = 0;
    // reserved rows carry no microvolt expectation
    bss_row_s rows [11] = '{
        '{1'b0, 2'h0, 6'h00, 22'h061A80, 1'b1, 1'b0},
        '{1'b0, 2'h1, 6'h07, 22'h08C618, 1'b1, 1'b0},
        '{1'b0, 2'h2, 6'h08, 22'h0927C0, 1'b1, 1'b0},
        '{1'b0, 2'h0, 6'h09, 22'h098968, 1'b0, 1'b0},
        '{1'b0, 2'h1, 6'h3F, 22'h1E22D8, 1'b0, 1'b0},
        '{1'b1, 2'h0, 6'h00, 22'h0C3500, 1'b0, 1'b0},
        '{1'b1, 2'h1, 6'h01, 22'h0CF850, 1'b0, 1'b0},
        '{1'b1, 2'h2, 6'h18, 22'h1E8480, 1'b0, 1'b0},
        '{1'b1, 2'h0, 6'h32, 22'h325AA0, 1'b0, 1'b0},
        '{1'b1, 2'h1, 6'h33, 22'h000000, 1'b0, 1'b1},
        '{1'b1, 2'h2, 6'h3F, 22'h000000, 1'b0, 1'b1}
    };
    assign hready = hreadyout;
    always #5 core_clk = ~core_clk;
    bss_setpoint bss_setpoint_i (
        .core_clk(core_clk), .rst_b(rst_b), .range_cfg(range_cfg),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .active_code(active_code), .active_microvolt(active_microvolt),
        .setpoint_too_low(setpoint_too_low),
        .setpoint_reserved(setpoint_reserved)
    );
    task final_report;
        $display("errors %0d, checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // wait for the slave, no fixed latency assumed
    task wait_rdy;
        @(posedge core_clk);
        while (hready !== 1'b1) begin
            @(posedge core_clk);
        end
    endtask : wait_rdy
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask : bus
    task do_reset(input logic r);
        rst_b <= 1'b0;
        range_cfg <= r;
        repeat (16) @(posedge core_clk);
        check({31'h0, hreadyout}, 32'h1);
        check(hrdata, 32'h0);
        check({25'h0, active_code}, 32'h0);
        rst_b <= 1'b1;
        @(posedge core_clk);
        for (int m = 0; m < 3; m++) begin
            bus(1'b0, 8'(m * 4), 32'h0);
            check(rd, {25'h0, r, 6'h00});
            lastc[m] = 6'h00;
        end
        repeat (4) @(posedge core_clk);
        check({25'h0, active_code}, {25'h0, r, 6'h00});
    endtask : do_reset
    task odd_cases(input logic r);
        bus(1'b1, `BSS_OFF_MODE, 32'h3);
        repeat (4) @(posedge core_clk);
        check({25'h0, active_code}, {25'h0, r, lastc[0]});
        bus(1'b1, 8'h14, 32'hFFFFFFFF);
        bus(1'b0, 8'h14, 32'h0);
        check(rd, 32'h0);
    endtask : odd_cases
    initial begin
        #200us;
        err_total++;
        final_report();
    end
    initial begin
        for (int i = 0; i < 11; i++) begin
            if (i == 0 || i == 5) begin
                do_reset(rows[i].rng);
            end
            // upper bits and an inverted range bit must be dropped
            bus(1'b1, {4'h0, rows[i].mode, 2'h0},
                {25'h1FFFFFF, ~rows[i].rng, rows[i].code});
            lastc[rows[i].mode] = rows[i].code;
            bus(1'b1, `BSS_OFF_MODE, {30'h0, rows[i].mode});
            repeat (4) @(posedge core_clk);
            check({25'h0, active_code}, {25'h0, rows[i].rng, rows[i].code});
            if (rows[i].res == 1'b0) begin
                check({10'h0, active_microvolt}, {10'h0, rows[i].uv});
            end
            check({30'h0, setpoint_too_low, setpoint_reserved},
                {30'h0, rows[i].low, rows[i].res});
            bus(1'b0, {4'h0, rows[i].mode, 2'h0}, 32'h0);
            check(rd, {25'h0, rows[i].rng, rows[i].code});
            bus(1'b0, `BSS_OFF_STATUS, 32'h0);
            check({23'h0, rd[31:30], rd[28:22]}, {23'h0, rows[i].res,
                rows[i].low, rows[i].rng, rows[i].code});
            if (i == 4 || i == 10) begin
                odd_cases(rows[i].rng);
            end
        end
        final_report();
    end
endmodule : test_buck_setpoint_select
